//--- shared/cmsf_pkg.sv
// Purpose: constants for the mailbox status flag block
// Assumes: 32 mailboxes, avalon-mm byte addressing
// Notes:   offsets are byte addresses, one 32-bit word each
package cmsf_pkg;
   localparam int unsigned MBX_CNT   = 32;
   localparam int unsigned HALF_CNT  = 16;
   localparam int unsigned ADDR_W    = 8;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_TX_CANCEL   = 8'h0c;
   localparam logic [7:0] OFF_TX_ACK      = 8'h10;
   localparam logic [7:0] OFF_ABORT_ACK   = 8'h14;
   localparam logic [7:0] OFF_RX_PEND     = 8'h18;
   localparam logic [7:0] OFF_RX_LOST     = 8'h1c;
   localparam logic [7:0] OFF_REMOTE_PEND = 8'h20;
   localparam logic [7:0] OFF_IFLAGS0     = 8'h3c;
   localparam logic [7:0] OFF_GMASK       = 8'h40;
   localparam logic [7:0] OFF_IFLAGS1     = 8'h44;
   localparam logic [7:0] OFF_MBX_MASK    = 8'h48;
   localparam logic [7:0] OFF_MBX_LEVEL   = 8'h4c;
   localparam logic [7:0] OFF_OVR_PROT    = 8'h50;
   localparam logic [7:0] OFF_CONFIG      = 8'h80;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned GMIF_BIT   = 15;
   localparam int unsigned ABORT_INTERRUPT_FLAG_BIT   = 14;
   localparam int unsigned LOST_INTERRUPT_FLAG_BIT  = 11;
   localparam int unsigned GM_LINE0   = 0;
   localparam int unsigned GM_LINE1   = 1;
   localparam int unsigned GM_AA      = 14;
   localparam int unsigned GM_RML     = 11;
   localparam int unsigned CFG_EXT    = 0;
   localparam logic [31:0] ZERO_W     = 32'h0000_0000;
   localparam logic [31:0] LOW_HALF   = 32'h0000_ffff;
   localparam logic [31:0] FULL_W     = 32'hffff_ffff;
   localparam logic [31:0] BAD_ADDR_R = 32'hdead_0bad;
   // bus states
   typedef enum logic [1:0] {
      CMSF_IDLE = 2'b01,
      CMSF_ACK  = 2'b10
   } cmsf_bus_e;
endpackage

//--- rtl/cmsf_status.sv
// Purpose: per-mailbox transmit/receive status flags of a can controller
// Assumes: protocol engine supplies one-cycle event pulses per mailbox
// Notes:   interrupt lines are levels built from the global flags
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cmsf_status (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   // avalon-mm slave
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // mailbox configuration from the rest of the controller
   input  wire logic [31:0] i_mbx_enable,
   input  wire logic [31:0] i_direction_bit,
   input  wire logic [31:0] i_auto_answer_bit,
   input  wire logic [31:0] i_request_set_bit,
   input  wire logic [31:0] i_tx_busy,
   // protocol engine events, one-cycle pulses
   input  wire logic [31:0] i_tx_done,
   input  wire logic [31:0] i_tx_remote_done,
   input  wire logic [31:0] i_tx_abort,
   input  wire logic [31:0] i_rx_store,
   input  wire logic [31:0] i_rx_remote,
   // status towards the protocol engine
   output logic [31:0]      o_cancel_withdraw,
   output logic [31:0]      o_overwrite_protect,
   output logic [31:0]      o_rx_pending,
   // interrupt lines
   output logic             o_irq_line0,
   output logic             o_irq_line1
);
   logic [31:0] tx_cancel_request_reg;
   logic [31:0] tx_acknowledge_flags_reg;
   logic [31:0] abort_acknowledge_flags_reg;
   logic [31:0] rx_pending_flags_reg;
   logic [31:0] rx_lost_flags_reg;
   logic [31:0] remote_pending_flags_reg;
   logic [31:0] mailbox_mask_reg;
   logic [31:0] mailbox_level_reg;
   logic [31:0] overwrite_protect_reg;
   logic [31:0] global_mask_reg;
   logic        ext_mode_reg;
   cmsf_pkg::cmsf_bus_e bus_state_reg;
   logic [31:0] impl_mask;
   logic [31:0] wmask;
   logic        wr_go;
   logic        rd_go;
   logic [31:0] w1;
   logic [31:0] tx_ok;
   logic [31:0] cancel_idle;
   logic [31:0] cancel_nak;
   logic [31:0] rx_overwrite;
   logic [31:0] mbx_event;
   logic        global_mailbox_flag_line0;
   logic        global_mailbox_flag_line1;
   logic        abort_interrupt_flag;
   logic        lost_interrupt_flag;
   logic [31:0] if0_word;
   logic [31:0] if1_word;
   logic [31:0] rd_mux;
   // ----------------------------------------------------------------
   // behaviour notes
   // ----------------------------------------------------------------
   // every access costs two cycles: one wait, then the acknowledge
   // edge; writes take effect on that acknowledge edge only
   // read data is captured in the wait cycle, so it is settled and
   // stable at the edge where waitrequest is sampled low
   // w1s and w1c act only on enabled byte lanes
   // the upper sixteen mailboxes are masked off until extended mode
   // is switched on; their flags then read as zero and never set
   // engine events are single-cycle pulses, one bit per mailbox
   // hardware sets beat software clears on the sticky flags, so no
   // event is ever lost to a racing clear
   // remote-pending is the exception: the clear wins there, so that
   // software can silence an auto-answer without a second pass
   // an accepted cancel is reported as an abort as well, so software
   // sees one acknowledge for every cancel it issues, except a cancel
   // ended by a sent remote request frame, which sets no flag
   // a frame already on the wire is never withdrawn; its cancel bit
   // waits for the success or abort of that frame
   // global flags are derived live from the sticky bits; clearing a
   // flag bit therefore also drops the interrupt it raised
   // the interrupt lines are registered to keep them glitch-free,
   // which costs one cycle of latency after the flag changes
   // routing of abort and lost flags to a line is one shared choice,
   // not per flag; this keeps the mask register small
   // mailbox level bits route each mailbox to one of the two lines
   // ----------------------------------------------------------------
   // bus slave: one wait cycle, then acknowledge
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         bus_state_reg <= cmsf_pkg::CMSF_IDLE;
      end else begin
         case (bus_state_reg)
            cmsf_pkg::CMSF_IDLE: begin
               if (i_avs_read || i_avs_write) begin
                  bus_state_reg <= cmsf_pkg::CMSF_ACK;
               end
            end
            cmsf_pkg::CMSF_ACK: bus_state_reg <= cmsf_pkg::CMSF_IDLE;
            default: bus_state_reg <= cmsf_pkg::CMSF_IDLE;
         endcase
      end
   end
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) &&
                              (bus_state_reg != cmsf_pkg::CMSF_ACK);
   assign wr_go = i_avs_write && (bus_state_reg == cmsf_pkg::CMSF_ACK);
   assign rd_go = i_avs_read && (bus_state_reg == cmsf_pkg::CMSF_ACK);
   // byte lanes become a bit mask
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_lane
         assign wmask[gb*8 +: 8] = {8{i_avs_byteenable[gb]}};
      end
   endgenerate
   assign impl_mask = ext_mode_reg ? cmsf_pkg::FULL_W : cmsf_pkg::LOW_HALF;
   assign w1 = i_avs_writedata & wmask & impl_mask;
   // ----------------------------------------------------------------
   // event qualification
   // ----------------------------------------------------------------
   // remote request frames never count as an acknowledged send
   assign tx_ok = i_tx_done & ~i_tx_remote_done & impl_mask;
   // only a request from request-set that is not on the wire is withdrawn
   assign o_cancel_withdraw = tx_cancel_request_reg & i_request_set_bit
                              & ~i_tx_busy & ~i_direction_bit & i_mbx_enable;
   assign cancel_idle = o_cancel_withdraw;
   assign cancel_nak  = tx_cancel_request_reg & (~i_request_set_bit | i_direction_bit
                        | ~i_mbx_enable) & impl_mask;
   // a reply to a remote request arrives as an ordinary store
   assign rx_overwrite = i_rx_store & rx_pending_flags_reg
                         & ~overwrite_protect_reg & impl_mask;
   assign o_overwrite_protect = overwrite_protect_reg;
   assign o_rx_pending = rx_pending_flags_reg;
   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         mailbox_mask_reg      <= cmsf_pkg::ZERO_W;
         mailbox_level_reg     <= cmsf_pkg::ZERO_W;
         overwrite_protect_reg <= cmsf_pkg::ZERO_W;
         global_mask_reg       <= cmsf_pkg::ZERO_W;
         ext_mode_reg          <= 1'b0;
      end else if (wr_go) begin
         case (i_avs_address)
            cmsf_pkg::OFF_MBX_MASK: begin
               mailbox_mask_reg <= (mailbox_mask_reg & ~wmask) | (w1 & wmask);
            end
            cmsf_pkg::OFF_MBX_LEVEL: begin
               mailbox_level_reg <= (mailbox_level_reg & ~wmask) | (w1 & wmask);
            end
            cmsf_pkg::OFF_OVR_PROT: begin
               overwrite_protect_reg <= (overwrite_protect_reg & ~wmask) | (w1 & wmask);
            end
            cmsf_pkg::OFF_GMASK: begin
               global_mask_reg <= (global_mask_reg & ~wmask) | (i_avs_writedata & wmask);
            end
            cmsf_pkg::OFF_CONFIG: begin
               if (i_avs_byteenable[0]) begin
                  ext_mode_reg <= i_avs_writedata[cmsf_pkg::CFG_EXT];
               end
            end
            default: begin
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   logic wr_trr;
   logic wr_ta;
   logic wr_aa;
   logic wr_rmp;
   logic wr_rfp;
   assign wr_trr = wr_go && (i_avs_address == cmsf_pkg::OFF_TX_CANCEL);
   assign wr_ta  = wr_go && (i_avs_address == cmsf_pkg::OFF_TX_ACK);
   assign wr_aa  = wr_go && (i_avs_address == cmsf_pkg::OFF_ABORT_ACK);
   assign wr_rmp = wr_go && (i_avs_address == cmsf_pkg::OFF_RX_PEND);
   assign wr_rfp = wr_go && (i_avs_address == cmsf_pkg::OFF_REMOTE_PEND);
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tx_cancel_request_reg <= cmsf_pkg::ZERO_W;
      end else begin
         // software set beats the hardware clear
         tx_cancel_request_reg <= ((tx_cancel_request_reg
            & ~(tx_ok | i_tx_abort | cancel_idle | cancel_nak | i_tx_remote_done))
            | (wr_trr ? w1 : cmsf_pkg::ZERO_W)) & impl_mask;
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tx_acknowledge_flags_reg <= cmsf_pkg::ZERO_W;
      end else begin
         tx_acknowledge_flags_reg <= ((tx_acknowledge_flags_reg
            & ~(wr_ta ? w1 : cmsf_pkg::ZERO_W)) | tx_ok) & impl_mask;
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         abort_acknowledge_flags_reg <= cmsf_pkg::ZERO_W;
      end else begin
         abort_acknowledge_flags_reg <= ((abort_acknowledge_flags_reg
            & ~(wr_aa ? w1 : cmsf_pkg::ZERO_W))
            | i_tx_abort | cancel_idle | cancel_nak) & impl_mask;
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         rx_pending_flags_reg <= cmsf_pkg::ZERO_W;
         rx_lost_flags_reg    <= cmsf_pkg::ZERO_W;
      end else begin
         rx_pending_flags_reg <= ((rx_pending_flags_reg
            & ~(wr_rmp ? w1 : cmsf_pkg::ZERO_W)) | i_rx_store) & impl_mask;
         rx_lost_flags_reg <= ((rx_lost_flags_reg
            & ~(wr_rmp ? w1 : cmsf_pkg::ZERO_W)) | rx_overwrite) & impl_mask;
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         remote_pending_flags_reg <= cmsf_pkg::ZERO_W;
      end else begin
         // here the software clear wins over a coinciding set
         remote_pending_flags_reg <= ((remote_pending_flags_reg
            | i_rx_remote)
            & ~(i_tx_done & i_auto_answer_bit & ~i_direction_bit)
            & ~(wr_rfp ? w1 : cmsf_pkg::ZERO_W)) & impl_mask;
      end
   end
   // ----------------------------------------------------------------
   // global flags and interrupt lines
   // ----------------------------------------------------------------
   // flags follow the sticky bits, so a w1c on them drops the line
   assign mbx_event = (tx_acknowledge_flags_reg | rx_pending_flags_reg)
                      & mailbox_mask_reg;
   assign global_mailbox_flag_line0 = |(mbx_event & ~mailbox_level_reg);
   assign global_mailbox_flag_line1 = |(mbx_event & mailbox_level_reg);
   assign abort_interrupt_flag  = |abort_acknowledge_flags_reg;
   assign lost_interrupt_flag = |rx_lost_flags_reg;
   always_comb begin
      if0_word = cmsf_pkg::ZERO_W;
      if1_word = cmsf_pkg::ZERO_W;
      if0_word[cmsf_pkg::GMIF_BIT]  = global_mailbox_flag_line0;
      if1_word[cmsf_pkg::GMIF_BIT]  = global_mailbox_flag_line1;
      if0_word[cmsf_pkg::ABORT_INTERRUPT_FLAG_BIT]  = abort_interrupt_flag && !global_mask_reg[cmsf_pkg::GM_LINE1];
      if1_word[cmsf_pkg::ABORT_INTERRUPT_FLAG_BIT]  = abort_interrupt_flag && global_mask_reg[cmsf_pkg::GM_LINE1];
      if0_word[cmsf_pkg::LOST_INTERRUPT_FLAG_BIT] = lost_interrupt_flag && !global_mask_reg[cmsf_pkg::GM_LINE1];
      if1_word[cmsf_pkg::LOST_INTERRUPT_FLAG_BIT] = lost_interrupt_flag && global_mask_reg[cmsf_pkg::GM_LINE1];
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_irq_line0 <= 1'b0;
         o_irq_line1 <= 1'b0;
      end else begin
         o_irq_line0 <= global_mask_reg[cmsf_pkg::GM_LINE0] && (global_mailbox_flag_line0
            || (if0_word[cmsf_pkg::ABORT_INTERRUPT_FLAG_BIT] && global_mask_reg[cmsf_pkg::GM_AA])
            || (if0_word[cmsf_pkg::LOST_INTERRUPT_FLAG_BIT] && global_mask_reg[cmsf_pkg::GM_RML]));
         o_irq_line1 <= global_mask_reg[cmsf_pkg::GM_LINE1] && (global_mailbox_flag_line1
            || (if1_word[cmsf_pkg::ABORT_INTERRUPT_FLAG_BIT] && global_mask_reg[cmsf_pkg::GM_AA])
            || (if1_word[cmsf_pkg::LOST_INTERRUPT_FLAG_BIT] && global_mask_reg[cmsf_pkg::GM_RML]));
      end
   end
   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb begin
      case (i_avs_address)
         cmsf_pkg::OFF_TX_CANCEL:   rd_mux = tx_cancel_request_reg;
         cmsf_pkg::OFF_TX_ACK:      rd_mux = tx_acknowledge_flags_reg;
         cmsf_pkg::OFF_ABORT_ACK:   rd_mux = abort_acknowledge_flags_reg;
         cmsf_pkg::OFF_RX_PEND:     rd_mux = rx_pending_flags_reg;
         cmsf_pkg::OFF_RX_LOST:     rd_mux = rx_lost_flags_reg;
         cmsf_pkg::OFF_REMOTE_PEND: rd_mux = remote_pending_flags_reg;
         cmsf_pkg::OFF_IFLAGS0:     rd_mux = if0_word;
         cmsf_pkg::OFF_IFLAGS1:     rd_mux = if1_word;
         cmsf_pkg::OFF_GMASK:       rd_mux = global_mask_reg;
         cmsf_pkg::OFF_MBX_MASK:    rd_mux = mailbox_mask_reg;
         cmsf_pkg::OFF_MBX_LEVEL:   rd_mux = mailbox_level_reg;
         cmsf_pkg::OFF_OVR_PROT:    rd_mux = overwrite_protect_reg;
         cmsf_pkg::OFF_CONFIG:      rd_mux = {31'h0000_0000, ext_mode_reg};
         default:                   rd_mux = cmsf_pkg::ZERO_W;
      endcase
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_avs_readdata <= cmsf_pkg::ZERO_W;
      end else if (i_avs_read && bus_state_reg == cmsf_pkg::CMSF_IDLE) begin
         o_avs_readdata <= rd_mux;
      end
   end
endmodule // cmsf_status
`default_nettype wire

//--- sim/cmsf_status_monitor.sv
// Purpose: port assertions for the mailbox status flags
// Assumes: masks are tracked from completed bus writes
// Notes:   interrupt raise checks cover mailboxes 15..0 only
`timescale 1ns/10ps
`default_nettype none
module cmsf_status_monitor (
   // clock, reset and bus
   input wire logic        i_clock,
   input wire logic        i_rst_n,
   input wire logic [7:0]  i_avs_address,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic        o_avs_waitrequest,
   // engine side
   input wire logic [31:0] i_request_set_bit,
   input wire logic [31:0] i_tx_busy,
   input wire logic [31:0] i_tx_done,
   input wire logic [31:0] i_tx_remote_done,
   input wire logic [31:0] i_tx_abort,
   input wire logic [31:0] i_rx_store,
   input wire logic [31:0] i_rx_remote,
   input wire logic [31:0] o_cancel_withdraw,
   input wire logic [31:0] o_rx_pending,
   input wire logic        o_irq_line0
);
   wire logic        wr = i_avs_write && !o_avs_waitrequest;
   wire logic [31:0] bm = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                           {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   wire logic [31:0] wv = i_avs_writedata & bm;
   wire logic        calm = !(|{i_tx_abort, i_rx_store, i_rx_remote}) && !i_avs_write;
   wire logic        idle = calm && !(|i_tx_done);
   logic [31:0]      mim_reg, mil_reg;
   logic             gim_reg, ext_reg;
   // shadow copies of the masks; lane merge keeps them exact on partial writes
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         {mim_reg, mil_reg, gim_reg, ext_reg} <= '0;
      end else if (wr) begin
         case (i_avs_address)
            cmsf_pkg::OFF_MBX_MASK:  mim_reg <= (mim_reg & ~bm) | wv;
            cmsf_pkg::OFF_MBX_LEVEL: mil_reg <= (mil_reg & ~bm) | wv;
            cmsf_pkg::OFF_GMASK:     gim_reg <= bm[0] ? wv[0] : gim_reg;
            cmsf_pkg::OFF_CONFIG:    ext_reg <= bm[0] ? wv[0] : ext_reg;
            default: ;
         endcase
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   a_tx_irq_raise: assert property (
      gim_reg && |(i_tx_done[15:0] & ~i_tx_remote_done[15:0] & mim_reg[15:0] & ~mil_reg[15:0])
      |-> ##2 o_irq_line0) else $error("tx done left line0 low");
   a_remote_quiet: assert property (
      idle ##1 (calm && !o_irq_line0 && |i_tx_done && i_tx_done == i_tx_remote_done) ##1 idle
      |=> !o_irq_line0) else $error("remote request raised line0");
   a_irq_fall_cause: assert property (
      $fell(o_irq_line0) |-> $past(wr) || $past(wr, 2)) else $error("line0 fell unasked");
   a_pend_set_now: assert property (
      |i_rx_store[15:0] |=> (o_rx_pending[15:0] & $past(i_rx_store[15:0]))
      == $past(i_rx_store[15:0])) else $error("pending not set by store");
   a_pend_sw_clear: assert property (
      |($past(o_rx_pending) & ~o_rx_pending) |-> $past(wr)
      && $past(i_avs_address) == cmsf_pkg::OFF_RX_PEND) else $error("pending cleared unasked");
   a_cancel_not_busy: assert property (
      (o_cancel_withdraw & i_tx_busy) == 32'h0) else $error("busy frame withdrawn");
   a_cancel_owned_req: assert property (
      (o_cancel_withdraw & ~i_request_set_bit) == 32'h0) else $error("withdraw without request");
   a_upper_dead_bits: assert property (
      !ext_reg |-> o_rx_pending[31:16] == 16'h0) else $error("upper pending in short mode");
   c_tx_irq: cover property (|i_tx_done[15:0] ##2 o_irq_line0);
   c_withdraw: cover property (|o_cancel_withdraw);
   c_pend_clear: cover property (|($past(o_rx_pending) & ~o_rx_pending));
endmodule // cmsf_status_monitor
bind cmsf_status cmsf_status_monitor mon_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_avs_address(i_avs_address), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
   .i_request_set_bit(i_request_set_bit), .i_tx_busy(i_tx_busy), .i_tx_done(i_tx_done),
   .i_tx_remote_done(i_tx_remote_done), .i_tx_abort(i_tx_abort), .i_rx_store(i_rx_store),
   .i_rx_remote(i_rx_remote), .o_cancel_withdraw(o_cancel_withdraw),
   .o_rx_pending(o_rx_pending), .o_irq_line0(o_irq_line0));
`default_nettype wire

//--- sim/cmsf_engine_model.sv
// Purpose: behavioural protocol engine beside the status block
// Assumes: one event kind per call
// Notes:   events are one-cycle pulses, no frame timing
`timescale 1ns/10ps
`default_nettype none
module cmsf_engine_model (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   // from the status block
   input  wire logic [31:0] i_cancel_withdraw,
   // towards the status block
   output logic [31:0]      o_request_set,
   output logic [31:0]      o_tx_done,
   output logic [31:0]      o_tx_remote_done,
   output logic [31:0]      o_tx_abort,
   output logic [31:0]      o_rx_store,
   output logic [31:0]      o_rx_remote
);
   logic [31:0] req_add_reg;
   initial begin
      {o_request_set, o_tx_done, o_tx_remote_done, o_tx_abort, o_rx_store} = '0;
      {o_rx_remote, req_add_reg} = '0;
   end
   // kind: 0 sent, 1 remote request sent, 2 abort, 3 stored (a remote reply too), 4 remote in
   task automatic fire(input logic [2:0] kind, input logic [31:0] m);
      @(posedge i_clock);
      case (kind)
         3'd0: o_tx_done <= m;
         3'd1: {o_tx_done, o_tx_remote_done} <= {m, m};
         3'd2: o_tx_abort <= m;
         3'd3: o_rx_store <= m;
         3'd4: o_rx_remote <= m;
         default: req_add_reg <= m;
      endcase
      @(posedge i_clock);
      {o_tx_done, o_tx_remote_done, o_tx_abort, o_rx_store, o_rx_remote, req_add_reg} <= '0;
   endtask
   // a request leaves only on success, abort or an accepted cancel
   always @(posedge i_clock) begin
      if (!i_rst_n) o_request_set <= 32'h0;
      else o_request_set <= (o_request_set | req_add_reg) & ~(i_cancel_withdraw | o_tx_done | o_tx_abort);
   end
endmodule // cmsf_engine_model
`default_nettype wire

//--- sim/test_cmsf_status.sv
// Purpose: self-checking bench for the mailbox status flags
// Assumes: full byte lanes on every access
// Notes:   mailbox 9 receives, 10 is disabled, 12 auto-answers
`timescale 1ns/10ps
`default_nettype none
module test_cmsf_status;
   logic        i_clock, i_rst_n, rd_en, wr_en, waitreq, irq0, irq1;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, q, mbx_en, dir_bits, auto_bits, busy, req_set, withdraw;
   logic [31:0] tx_done, rem_done, abort, rx_store, rx_remote, overwrite_protect_bit, pend;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;
   cmsf_status dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(addr),
      .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_mbx_enable(mbx_en),
      .i_direction_bit(dir_bits), .i_auto_answer_bit(auto_bits), .i_request_set_bit(req_set),
      .i_tx_busy(busy), .i_tx_done(tx_done), .i_tx_remote_done(rem_done), .i_tx_abort(abort),
      .i_rx_store(rx_store), .i_rx_remote(rx_remote), .o_cancel_withdraw(withdraw),
      .o_overwrite_protect(overwrite_protect_bit), .o_rx_pending(pend), .o_irq_line0(irq0), .o_irq_line1(irq1));
   cmsf_engine_model eng_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cancel_withdraw(withdraw),
      .o_request_set(req_set), .o_tx_done(tx_done), .o_tx_remote_done(rem_done),
      .o_tx_abort(abort), .o_rx_store(rx_store), .o_rx_remote(rx_remote));
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // the run should need well under a thousand cycles
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         tally_and_finish;
      end
   end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      addr  <= a;
      wdata <= d;
      wr_en <= w;
      rd_en <= !w;
      do @(posedge i_clock); while (waitreq !== 1'b0);
      q = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), e, q);
   endtask
   // software clear lands on the same edge as the engine event
   task automatic both(input logic [7:0] a, input logic [31:0] d, input logic [2:0] k);
      fork
         wr(a, d);
         begin @(posedge i_clock); eng_u.fire(k, d); end
      join
   endtask
   initial begin
      {i_rst_n, rd_en, wr_en, addr, wdata, busy} = '0;
      mbx_en = 32'hffff_fbff;
      dir_bits = 32'h0000_0200;
      auto_bits = 32'h0000_1000;
      repeat (20) @(posedge i_clock);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) rd(cmsf_pkg::OFF_TX_CANCEL + 8'(4 * i), 32'h0);
      wr(cmsf_pkg::OFF_MBX_MASK, 32'h0000_ffff);
      wr(cmsf_pkg::OFF_GMASK, 32'h0000_4801);
      eng_u.fire(3'd0, 32'h8);
      rd(cmsf_pkg::OFF_IFLAGS0, 32'h0000_8000);
      chk("line0", 32'h1, {31'h0, irq0});
      wr(cmsf_pkg::OFF_TX_ACK, 32'h0);
      both(cmsf_pkg::OFF_TX_ACK, 32'h8, 3'd0);
      rd(cmsf_pkg::OFF_TX_ACK, 32'h8);
      wr(cmsf_pkg::OFF_TX_ACK, 32'h8);
      rd(cmsf_pkg::OFF_IFLAGS0, 32'h0);
      chk("line0", 32'h0, {31'h0, irq0});
      eng_u.fire(3'd1, 32'h10);
      rd(cmsf_pkg::OFF_TX_ACK, 32'h0);
      chk("line0", 32'h0, {31'h0, irq0});
      eng_u.fire(3'd2, 32'h20);
      rd(cmsf_pkg::OFF_IFLAGS0, 32'h0000_4000);
      chk("line0", 32'h1, {31'h0, irq0});
      both(cmsf_pkg::OFF_ABORT_ACK, 32'h20, 3'd2);
      rd(cmsf_pkg::OFF_ABORT_ACK, 32'h20);
      wr(cmsf_pkg::OFF_ABORT_ACK, 32'h20);
      rd(cmsf_pkg::OFF_ABORT_ACK, 32'h0);
      wr(cmsf_pkg::OFF_TX_CANCEL, 32'h40);
      rd(cmsf_pkg::OFF_ABORT_ACK, 32'h40);
      rd(cmsf_pkg::OFF_TX_CANCEL, 32'h0);
      eng_u.fire(3'd5, 32'h0000_0780);
      busy <= 32'h0000_0100;
      wr(cmsf_pkg::OFF_TX_CANCEL, 32'h0000_0780);
      // the engine drops the request one edge after the withdraw shows
      repeat (2) @(posedge i_clock);
      chk("request", 32'h0000_0100, req_set & 32'h0000_0180);
      rd(cmsf_pkg::OFF_ABORT_ACK, 32'h0000_06c0);
      rd(cmsf_pkg::OFF_TX_CANCEL, 32'h0000_0100);
      eng_u.fire(3'd0, 32'h0000_0100);
      busy <= 32'h0;
      rd(cmsf_pkg::OFF_TX_CANCEL, 32'h0);
      rd(cmsf_pkg::OFF_TX_ACK, 32'h0000_0100);
      wr(cmsf_pkg::OFF_TX_ACK, 32'h0000_0100);
      wr(cmsf_pkg::OFF_ABORT_ACK, 32'h0000_06c0);
      eng_u.fire(3'd3, 32'h4);
      eng_u.fire(3'd3, 32'h4);
      rd(cmsf_pkg::OFF_IFLAGS0, 32'h0000_8800);
      both(cmsf_pkg::OFF_RX_PEND, 32'h4, 3'd3);
      rd(cmsf_pkg::OFF_RX_LOST, 32'h4);
      wr(cmsf_pkg::OFF_RX_PEND, 32'h4);
      rd(cmsf_pkg::OFF_RX_LOST, 32'h0);
      wr(cmsf_pkg::OFF_OVR_PROT, 32'h2);
      eng_u.fire(3'd3, 32'h2);
      eng_u.fire(3'd3, 32'h2);
      rd(cmsf_pkg::OFF_RX_LOST, 32'h0);
      chk("pending", 32'h2, pend);
      chk("protect", 32'h2, overwrite_protect_bit);
      eng_u.fire(3'd4, 32'h1000);
      both(cmsf_pkg::OFF_REMOTE_PEND, 32'h2000, 3'd4);
      rd(cmsf_pkg::OFF_REMOTE_PEND, 32'h1000);
      eng_u.fire(3'd0, 32'h1000);
      rd(cmsf_pkg::OFF_REMOTE_PEND, 32'h0);
      eng_u.fire(3'd4, 32'h1000);
      wr(cmsf_pkg::OFF_REMOTE_PEND, 32'h1000);
      wr(cmsf_pkg::OFF_TX_CANCEL, 32'h1000);
      rd(cmsf_pkg::OFF_REMOTE_PEND, 32'h0);
      wr(cmsf_pkg::OFF_GMASK, 32'h0000_4803);
      wr(cmsf_pkg::OFF_MBX_LEVEL, 32'h0000_1000);
      rd(cmsf_pkg::OFF_IFLAGS1, 32'h0000_c000);
      chk("line1", 32'h1, {31'h0, irq1});
      eng_u.fire(3'd3, 32'h0010_0000);
      rd(cmsf_pkg::OFF_RX_PEND, 32'h2);
      wr(cmsf_pkg::OFF_CONFIG, 32'h1);
      eng_u.fire(3'd3, 32'h0010_0000);
      rd(cmsf_pkg::OFF_RX_PEND, 32'h0010_0002);
      wr(8'h60, 32'hffff_ffff);
      rd(8'h60, 32'h0);
      tally_and_finish;
   end
endmodule // test_cmsf_status
`default_nettype wire
